// ===== hw/ssf_map.vh
// Register map, field positions, reset values and timing counts
// for the serial status flags and data buffer block.
// Assumes an 8-bit register port with a 2-bit word address.
`ifndef SSF_MAP_VH
`define SSF_MAP_VH

// Register addresses
`define SSF_ADDR_CTRL_ONE 2'h0
`define SSF_ADDR_STATUS 2'h1
`define SSF_ADDR_DATA 2'h2

// Status flag positions
`define SSF_STAT_RXF_BIT 7
`define SSF_STAT_TXE_BIT 5
`define SSF_STAT_MASTER_FAULT_FLAG_BIT 4

// Control register one field positions
`define SSF_CTL_ENABLE_BIT 7
`define SSF_CTL_RXIE_BIT 6
`define SSF_CTL_TXIE_BIT 5
`define SSF_CTL_MASTER_BIT 4
`define SSF_CTL_SELECT_OUTPUT_ENABLE_BIT 1
`define SSF_CTL_FDEN_BIT 0

// Reset values
`define SSF_CTL_RESET 8'h00
`define SSF_BYTE_RESET 8'h00
`define SSF_UNMAPPED_READ 8'h00

// Timing: master serial clock half period, in ns, and bus clock period
`define SSF_SCK_HALF_NS 80
`define SSF_CLK_PERIOD_NS 20
`define SSF_SCK_HALF_CYC (`SSF_SCK_HALF_NS / `SSF_CLK_PERIOD_NS)

// Bits per transfer
`define SSF_BITS_PER_XFER 4'h8

`endif

// ===== hw/ssf_sync.v
// Two-flop synchroniser bank for the serial pins.
// Assumes the inputs are asynchronous to the bus clock.
`timescale 1ns/10ps

module ssf_sync
#(
  parameter W = 4
)
(
  input wire clk_i,
  input wire arst_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] stab_r;

  ////////////////////////////////////////////////////////////////////////
  // One synchroniser per pin; first flop feeds only the second
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      always @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          meta_r[g] <= 1'b1;
          stab_r[g] <= 1'b1;
        end
        else
        begin
          meta_r[g] <= async_i[g];
          stab_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = stab_r;

endmodule // ssf_sync

// ===== hw/ssf_core.v
// Status flags, double-buffered data port and byte shifter of a
// byte-wide synchronous serial interface, with its control register.
// Assumes a single-cycle register port on SYS_CLK_I; serial pins are
// asynchronous and pass the synchroniser bank before use.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "ssf_map.vh"

module ssf_core
(
  input wire SYS_CLK_I,
  input wire ARST_N_I,
  input wire [1:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  input wire SCK_I,
  output reg SCK_O,
  output reg SCK_OE_O,
  input wire SS_N_I,
  output reg SS_N_O,
  output reg SS_N_OE_O,
  input wire MOSI_I,
  output reg MOSI_O,
  output reg MOSI_OE_O,
  input wire MISO_I,
  output reg MISO_O,
  output reg MISO_OE_O,
  output reg TX_IRQ_O,
  output reg RX_IRQ_O
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_BUSY = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [31:0] HALF_FULL = `SSF_SCK_HALF_CYC - 1;
  localparam [3:0] HALF_LAST = HALF_FULL[3:0];

  reg [7:0] ctrl_r;
  reg [7:0] tx_buf_r;
  reg tx_full_r;
  reg [7:0] rx_buf_r;
  reg rx_full_r;
  reg master_fault_flag_r;
  reg rxf_seen_r;
  reg txe_seen_r;
  reg master_fault_flag_seen_r;
  reg [7:0] shift_r;
  reg shift_full_r;
  reg rx_bit_r;
  reg [1:0] state_r;
  reg [3:0] bits_r;
  reg [3:0] half_cnt_r;
  reg sck_gen_r;
  reg sck_d_r;

  wire [3:0] pin_sync;
  wire sck_s;
  wire ss_n_s;
  wire mosi_s;
  wire miso_s;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ssf_sync #(.W(4)) u_sync
  (
    .clk_i(SYS_CLK_I),
    .arst_n_i(ARST_N_I),
    .async_i({SCK_I, SS_N_I, MOSI_I, MISO_I}),
    .sync_o(pin_sync)
  );

  assign sck_s = pin_sync[3];
  assign ss_n_s = pin_sync[2];
  assign mosi_s = pin_sync[1];
  assign miso_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // Control fields and flag views
  wire enable = ctrl_r[`SSF_CTL_ENABLE_BIT];
  wire rx_ie = ctrl_r[`SSF_CTL_RXIE_BIT];
  wire tx_ie = ctrl_r[`SSF_CTL_TXIE_BIT];
  wire master = ctrl_r[`SSF_CTL_MASTER_BIT];
  wire select_output_enable = ctrl_r[`SSF_CTL_SELECT_OUTPUT_ENABLE_BIT];
  wire fden = ctrl_r[`SSF_CTL_FDEN_BIT];
  wire txe = ~tx_full_r;

  // Register port decode
  wire wr_ctrl = WR_I && (ADDR_I == `SSF_ADDR_CTRL_ONE);
  wire wr_data = WR_I && (ADDR_I == `SSF_ADDR_DATA);
  wire rd_stat = RD_I && (ADDR_I == `SSF_ADDR_STATUS);
  wire rd_data = RD_I && (ADDR_I == `SSF_ADDR_DATA);

  wire wr_accept = wr_data && txe_seen_r;

  wire [7:0] status_val = {rx_full_r, 1'b0, txe, master_fault_flag_r, 4'h0};

  ////////////////////////////////////////////////////////////////////////
  // Serial sequencing events
  wire busy = (state_r == ST_BUSY);
  wire sck_rise_in = sck_s & ~sck_d_r;
  wire sck_fall_in = ~sck_s & sck_d_r;
  wire m_tick = busy && master && (half_cnt_r == HALF_LAST);
  wire m_rise = m_tick && ~sck_gen_r;
  wire m_fall = m_tick && sck_gen_r;
  wire s_rise = busy && ~master && sck_rise_in;
  wire s_fall = busy && ~master && sck_fall_in;
  wire xfer_done = (m_fall && (bits_r == `SSF_BITS_PER_XFER)) ||
                   (s_rise && (bits_r == `SSF_BITS_PER_XFER - 4'h1));
  wire do_shift = (m_fall && (bits_r != `SSF_BITS_PER_XFER)) || (s_fall && (bits_r != 4'h0));
  wire [7:0] rx_byte = {shift_r[6:0], (m_fall ? rx_bit_r : mosi_s)};

  wire fault_armed = enable && master && fden && ~select_output_enable;
  wire master_fault_flag_set = fault_armed && ~ss_n_s;

  // Move when shifter free and idle
  wire tx_move = tx_full_r && ~shift_full_r && ~busy;
  wire rxf_set = xfer_done && ~rx_full_r;

  ////////////////////////////////////////////////////////////////////////
  // Control register one; writes also finish the fault clear sequence
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ctrl_r <= `SSF_CTL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_r <= WDATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clear-sequence arming, taken from what a status read observed
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rxf_seen_r <= 1'b0;
      txe_seen_r <= 1'b0;
      master_fault_flag_seen_r <= 1'b0;
    end
    else
    begin
      if (rd_stat)
      begin
        rxf_seen_r <= rx_full_r;
      end
      else if (rd_data)
      begin
        rxf_seen_r <= 1'b0;
      end
      if (rd_stat)
      begin
        txe_seen_r <= txe;
      end
      else if (wr_data)
      begin
        txe_seen_r <= 1'b0;
      end
      if (rd_stat)
      begin
        master_fault_flag_seen_r <= master_fault_flag_r;
      end
      else if (wr_ctrl)
      begin
        master_fault_flag_seen_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer and its full flag
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rx_buf_r <= `SSF_BYTE_RESET;
      rx_full_r <= 1'b0;
    end
    else
    begin
      if (rxf_set)
      begin
        rx_buf_r <= rx_byte;
      end
      if (rxf_set)
      begin
        rx_full_r <= 1'b1;
      end
      else if (rd_data && rxf_seen_r)
      begin
        rx_full_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode fault flag; set beats the completing control write
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      master_fault_flag_r <= 1'b0;
    end
    else if (master_fault_flag_set)
    begin
      master_fault_flag_r <= 1'b1;
    end
    else if (wr_ctrl && master_fault_flag_seen_r)
    begin
      master_fault_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit buffer; empty flag is its complement
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      tx_buf_r <= `SSF_BYTE_RESET;
      tx_full_r <= 1'b0;
    end
    else if (wr_accept)
    begin
      tx_buf_r <= WDATA_I;
      tx_full_r <= 1'b1;
    end
    else if (tx_move)
    begin
      tx_full_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shifter: loaded from the buffer, shifted MSB first, freed on completion
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      shift_r <= `SSF_BYTE_RESET;
      shift_full_r <= 1'b0;
      rx_bit_r <= 1'b0;
    end
    else
    begin
      if (tx_move)
      begin
        shift_r <= tx_buf_r;
        shift_full_r <= 1'b1;
      end
      else if (do_shift)
      begin
        shift_r <= {shift_r[6:0], rx_bit_r};
      end
      else if (xfer_done)
      begin
        shift_r <= rx_byte;
        shift_full_r <= 1'b0;
      end
      // Sample on rising serial edge
      if (m_rise)
      begin
        rx_bit_r <= miso_s;
      end
      else if (s_rise)
      begin
        rx_bit_r <= mosi_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencer for both roles
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state_r <= ST_IDLE;
      bits_r <= 4'h0;
      half_cnt_r <= 4'h0;
      sck_gen_r <= 1'b0;
      sck_d_r <= 1'b1; // Matches synchroniser reset level, no false rise
    end
    else
    begin
      sck_d_r <= sck_s;
      if (!enable)
      begin
        state_r <= ST_IDLE;
        bits_r <= 4'h0;
        half_cnt_r <= 4'h0;
        sck_gen_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            bits_r <= 4'h0;
            half_cnt_r <= 4'h0;
            sck_gen_r <= 1'b0;
            if (master && shift_full_r)
            begin
              state_r <= ST_BUSY;
            end
            else if (!master && !ss_n_s)
            begin
              state_r <= ST_BUSY;
            end
          end
          ST_BUSY:
          begin
            if (master)
            begin
              // Divider enable produces the serial clock half periods
              half_cnt_r <= m_tick ? 4'h0 : half_cnt_r + 4'h1;
              if (m_tick)
              begin
                sck_gen_r <= ~sck_gen_r;
              end
              if (m_rise)
              begin
                bits_r <= bits_r + 4'h1;
              end
              // End returns to idle and forces the serial clock low
              if (xfer_done)
              begin
                state_r <= ST_IDLE;
                sck_gen_r <= 1'b0;
              end
            end
            else if (ss_n_s)
            begin
              // Deselected mid-byte: abandon the partial byte
              state_r <= ST_IDLE;
            end
            else
            begin
              if (s_rise)
              begin
                bits_r <= bits_r + 4'h1;
              end
              if (xfer_done)
              begin
                state_r <= ST_WAIT;
              end
            end
          end
          ST_WAIT:
          begin
            // Slave waits for deselect before the next byte
            if (ss_n_s || master)
            begin
              state_r <= ST_IDLE;
            end
          end
          default:
          begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port; data stand one cycle after the strobe
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      RDATA_O <= `SSF_UNMAPPED_READ;
    end
    else if (RD_I)
    begin
      case (ADDR_I)
        `SSF_ADDR_CTRL_ONE: RDATA_O <= ctrl_r;
        `SSF_ADDR_STATUS: RDATA_O <= status_val;
        `SSF_ADDR_DATA: RDATA_O <= rx_buf_r;
        default: RDATA_O <= `SSF_UNMAPPED_READ;
      endcase
    end
    else
    begin
      RDATA_O <= `SSF_UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered pin drivers and interrupt requests
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      SCK_O <= 1'b0;
      SCK_OE_O <= 1'b0;
      SS_N_O <= 1'b1;
      SS_N_OE_O <= 1'b0;
      MOSI_O <= 1'b0;
      MOSI_OE_O <= 1'b0;
      MISO_O <= 1'b0;
      MISO_OE_O <= 1'b0;
      TX_IRQ_O <= 1'b0;
      RX_IRQ_O <= 1'b0;
    end
    else
    begin
      SCK_O <= sck_gen_r;
      SCK_OE_O <= enable && master;
      SS_N_O <= ~busy;
      SS_N_OE_O <= enable && master && fden && select_output_enable;
      MOSI_O <= shift_r[7];
      MOSI_OE_O <= enable && master;
      MISO_O <= shift_r[7];
      // Slave drives only while selected, so several can share the line
      MISO_OE_O <= enable && ~master && ~ss_n_s;
      TX_IRQ_O <= txe && tx_ie;
      RX_IRQ_O <= (rx_full_r || master_fault_flag_r) && rx_ie;
    end
  end

endmodule // ssf_core

// ===== dv/ssf_core_asserts.sv
// Checker for the register port, interrupt lines and link clock.
// Assumes it is bound to ssf_core and sees only its ports.
`timescale 1ns/10ps
module ssf_core_asserts
(
  input wire SYS_CLK_I,
  input wire ARST_N_I,
  input wire [1:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [7:0] RDATA_O,
  input wire SCK_O,
  input wire SCK_OE_O,
  input wire SS_N_O,
  input wire SS_N_OE_O,
  input wire MOSI_OE_O,
  input wire MISO_OE_O,
  input wire SS_N_I,
  input wire TX_IRQ_O,
  input wire RX_IRQ_O
);
  reg [7:0] ctl_r;
  reg st_rd_r;
  reg arm_r;
  // A status read answered this cycle arms at once
  wire arm_now = st_rd_r ? RDATA_O[5] : arm_r;
  // Mirror of control register one and of the transmit arming
  always @(posedge SYS_CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
    begin
      ctl_r <= 8'h00;
      st_rd_r <= 1'b0;
      arm_r <= 1'b0;
    end
    else
    begin
      if (WR_I && ADDR_I == 2'h0)
        ctl_r <= WDATA_I;
      st_rd_r <= RD_I && ADDR_I == 2'h1;
      if (WR_I && ADDR_I == 2'h2)
        arm_r <= 1'b0;
      else if (st_rd_r)
        arm_r <= RDATA_O[5];
    end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  property p_stat_zero;
    (RD_I && ADDR_I == 2'h1) |=> (RDATA_O & 8'h4F) == 8'h00;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status spare bits set");
  property p_unmap_zero;
    (RD_I && ADDR_I == 2'h3) |=> RDATA_O == 8'h00;
  endproperty
  a_unmap_zero: assert property (p_unmap_zero) else $error("unmapped read not zero");
  property p_tx_irq_flag;
    (RD_I && ADDR_I == 2'h1 && ctl_r[5]) |=> TX_IRQ_O == RDATA_O[5];
  endproperty
  a_tx_irq_flag: assert property (p_tx_irq_flag) else $error("tx request differs from flag");
  property p_tx_irq_off;
    !$past(ctl_r[5]) |-> !TX_IRQ_O;
  endproperty
  a_tx_irq_off: assert property (p_tx_irq_off) else $error("tx request while masked");
  property p_rx_irq_flag;
    (RD_I && ADDR_I == 2'h1 && ctl_r[6]) |=> RX_IRQ_O == (RDATA_O[7] | RDATA_O[4]);
  endproperty
  a_rx_irq_flag: assert property (p_rx_irq_flag) else $error("rx request differs from flags");
  property p_fault_irq;
    ((ctl_r & 8'hD3) == 8'hD1 && !SS_N_I) [*4] |-> ##[0:4] RX_IRQ_O;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("select low gave no fault");
  property p_load_starts;
    (WR_I && ADDR_I == 2'h2 && arm_now && ctl_r[7] && ctl_r[4]) |-> ##[1:200] $rose(SCK_O);
  endproperty
  a_load_starts: assert property (p_load_starts) else $error("load started no transfer");
  property p_sck_half;
    $rose(SCK_O) |-> SCK_O [*4] ##1 !SCK_O;
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("serial clock high time wrong");
  // Pin enables follow control one cycle late; slave enable lags select by the synchroniser
  property p_master_oe;
    SCK_OE_O == $past(ctl_r[7] && ctl_r[4]) && MOSI_OE_O == SCK_OE_O;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("master pin enables wrong");
  property p_sel_oe;
    SS_N_OE_O == $past((ctl_r & 8'h93) == 8'h93);
  endproperty
  a_sel_oe: assert property (p_sel_oe) else $error("select output enable wrong");
  property p_slave_oe;
    MISO_OE_O == ($past(ctl_r[7] && !ctl_r[4]) && $past(!SS_N_I, 3));
  endproperty
  a_slave_oe: assert property (p_slave_oe) else $error("slave data enable wrong");
  property p_sel_out;
    $rose(SCK_O) |-> !SS_N_O;
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("select high during transfer");
endmodule // ssf_core_asserts
bind ssf_core ssf_core_asserts u_chk (.SYS_CLK_I, .ARST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .SCK_O, .SCK_OE_O, .SS_N_O, .SS_N_OE_O, .MOSI_OE_O, .MISO_OE_O, .SS_N_I,
  .TX_IRQ_O, .RX_IRQ_O);

// ===== dv/ssf_peer.sv
// Serial slave model facing the master pins of the flag block.
// Assumes clock mode 0: sample on rise, next bit on fall.
`timescale 1ns/10ps
module ssf_peer
(
  input wire sck_i,
  input wire mosi_i,
  input wire load_i,
  input wire [15:0] tx_i,
  output wire miso_o,
  output reg [15:0] rx_o,
  output reg [4:0] cnt_o
);
  reg [15:0] sh_r;
  // Released line shows the inverse so a stale bit cannot pass
  assign miso_o = (cnt_o < 5'd16) ? sh_r[15] : ~rx_o[0];
  // eight bits a byte, MSB first
  always @(posedge sck_i or posedge load_i)
    if (load_i)
      cnt_o <= 5'd0;
    else
    begin
      rx_o <= {rx_o[14:0], mosi_i};
      cnt_o <= cnt_o + 5'd1;
    end
  // Reply bits move on the falling edge
  always @(negedge sck_i or posedge load_i)
    if (load_i)
      sh_r <= tx_i;
    else
      sh_r <= sh_r << 1;
endmodule // ssf_peer

// ===== dv/ssf_core_tb.sv
// Self-checking bench for the flag block in master and slave roles.
// Assumes a 50 MHz bus clock and a slave model on the link pins.
`timescale 1ns/10ps
module ssf_core_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] addr = 2'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg ss_n = 1'b1;
  reg sck_in = 1'b0;
  reg mosi_in = 1'b0;
  reg load = 1'b0;
  reg rd_seen = 1'b0;
  reg [15:0] ptx = 16'h0000;
  reg [31:0] seed = 32'd43367;
  reg [7:0] a_b, c_b, b_b;
  reg [7:0] q_exp[$];
  reg [7:0] q_msk[$];
  wire [7:0] rdata;
  wire sck, mosi, miso;
  wire [15:0] prx;
  wire [4:0] pcnt;
  integer err_count = 0;
  integer compares = 0;
  integer i, j;
  ////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  ssf_core dut
  (
    .SYS_CLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SCK_I(sck_in), .SCK_O(sck), .SCK_OE_O(), .SS_N_I(ss_n), .SS_N_O(),
    .SS_N_OE_O(), .MOSI_I(mosi_in), .MOSI_O(mosi), .MOSI_OE_O(), .MISO_I(miso), .MISO_O(),
    .MISO_OE_O(), .TX_IRQ_O(), .RX_IRQ_O()
  );
  ssf_peer peer (.sck_i(sck), .mosi_i(mosi), .load_i(load), .tx_i(ptx), .miso_o(miso), .rx_o(prx), .cnt_o(pcnt));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task wr_reg(input [1:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  // Expected read value and mask are queued for the monitor
  task rd_reg(input [1:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      q_exp.push_back(e);
      q_msk.push_back(m);
      @(posedge clk);
      rd <= 1'b0;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t: link %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for the slave to count bits, then let flags settle
  task wait_bits(input [4:0] n);
    begin
      for (i = 0; i < 400 && pcnt < n; i = i + 1)
        @(posedge clk);
      repeat (12) @(posedge clk);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Read data is valid one cycle after the strobe, compared there
  always @(posedge clk)
    rd_seen <= rd;
  always @(negedge clk)
    if (rd_seen)
    begin
      compares = compares + 1;
      if ((rdata & q_msk[0]) !== (q_exp[0] & q_msk[0]))
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t: read %h expected %h", $time, rdata, q_exp[0]);
      end
      q_exp.pop_front();
      q_msk.pop_front();
    end
  // Main sequence
  initial
  begin
    seed = xs(seed);
    {ptx, c_b, a_b} = seed;
    seed = xs(seed);
    b_b = seed[7:0];
    // Peer loads only after the serial clock output has left its unknown start
    repeat (4) @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    rst_n <= 1'b1;
    wr_reg(2'h0, 8'hB0);
    wr_reg(2'h2, 8'h5A);
    rd_reg(2'h1, 8'h20, 8'hFF);
    wr_reg(2'h1, 8'hFF);
    rd_reg(2'h1, 8'h20, 8'hFF);
    rd_reg(2'h3, 8'h00, 8'hFF);
    // Idle load moves at once, the second byte queues behind it
    rd_reg(2'h1, 8'h20, 8'hFF);
    wr_reg(2'h2, a_b);
    rd_reg(2'h1, 8'h20, 8'hFF);
    wr_reg(2'h2, c_b);
    rd_reg(2'h1, 8'h00, 8'h20);
    wait_bits(5'd8);
    rd_reg(2'h1, 8'hA0, 8'hFF);
    wait_bits(5'd16);
    rd_reg(2'h1, 8'hA0, 8'hFF);
    rd_reg(2'h2, ptx[15:8], 8'hFF);
    rd_reg(2'h1, 8'h20, 8'hFF);
    chk(prx, {a_b, c_b});
    chk({11'h000, pcnt}, 16'h0010);
    // Select pulled low under three master settings, one of them armed
    for (j = 0; j < 3; j = j + 1)
    begin
      wr_reg(2'h0, 8'hD3 - j[7:0]);
      ss_n <= 1'b0;
      repeat (6) @(posedge clk);
      ss_n <= 1'b1;
      rd_reg(2'h1, {3'h1, j == 2, 4'h0}, 8'hFF);
      wr_reg(2'h0, 8'hD1);
      rd_reg(2'h1, 8'h20, 8'hFF);
    end
    // Slave role: the bench plays master, 160 ns serial clock, data moves on fall
    wr_reg(2'h0, 8'h80);
    ss_n <= 1'b0;
    for (j = 7; j >= 0; j = j - 1)
    begin
      mosi_in <= b_b[j];
      repeat (4) @(posedge clk);
      sck_in <= 1'b1;
      repeat (4) @(posedge clk);
      sck_in <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    rd_reg(2'h1, 8'hA0, 8'hFF);
    rd_reg(2'h2, b_b, 8'hFF);
    repeat (4) @(posedge clk);
    final_report;
  end
  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count = err_count + 1;
    final_report;
  end
endmodule // ssf_core_tb
